/* File: plw_pkg.sv */
// constants, register map and types of the program loop watchdog
package plw_pkg;

  // =========================================================
  // register indices, byte address is four times the index
  localparam logic [15:0] MODE_IDX = 16'hff98;
  localparam logic [15:0] RESTART_IDX = 16'hff99;
  localparam logic [15:0] STATUS_IDX = 16'hff9a;

  // =========================================================
  // values
  localparam logic [7:0] MODE_RESET = 8'h67;
  localparam logic [7:0] RESTART_KEY = 8'hac;
  localparam logic [7:0] RESTART_READ = 8'h9a;
  localparam logic [2:0] FIXED_BITS = 3'h3;
  localparam logic [1:0] SEL_LOWSPEED = 2'h0;
  localparam logic [1:0] SEL_CRYSTAL = 2'h1;
  localparam int SEL_STOP_BIT = 1;

  // =========================================================
  // counter geometry
  localparam int CNT_W = 21;
  localparam logic [4:0] LS_BASE_EXP = 5'h0b;
  localparam logic [4:0] XT_BASE_EXP = 5'h0d;

  // =========================================================
  // status register bit positions
  localparam int ST_WRITTEN = 0;
  localparam int ST_STOPPED = 1;
  localparam int ST_UNSTOP = 2;
  localparam int ST_CAUSE = 3;

  typedef struct packed {
    logic [2:0] fixed;
    logic [1:0] clk_sel;
    logic [2:0] interval;
  } plw_mode_t;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WAIT,
    BUS_ACK
  } plw_bus_t;

endpackage

/* File: plw_watchdog.sv */
// program loop watchdog with classic wishbone register slave
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/10ps
module plw_watchdog (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic bit_access_i,
  input wire logic option_unstoppable_i,
  input wire logic halt_i,
  input wire logic stop_i,
  input wire logic lowspeed_osc_clk_i,
  input wire logic crystal_tick_i,
  output logic wd_reset_o,
  output logic wd_reset_cause_flag_o
);

  // =========================================================
  // address decode
  function automatic logic reg_hit(input logic [31:0] adr, input logic [15:0] idx);
    reg_hit = (adr == {14'h0000, idx, 2'h0});
  endfunction

  // overflow limit: last count value of the selected period
  function automatic logic [plw_pkg::CNT_W-1:0] last_count(input logic crystal,
                                                          input logic [2:0] code);
    logic [4:0] expo;
    expo = (crystal ? plw_pkg::XT_BASE_EXP : plw_pkg::LS_BASE_EXP) + {2'h0, code};
    last_count = plw_pkg::CNT_W'((22'h00_0001 << expo) - 22'h00_0001);
  endfunction

  plw_pkg::plw_bus_t state;
  plw_pkg::plw_mode_t mode;
  logic mode_written;
  logic [plw_pkg::CNT_W-1:0] cnt;
  logic req;
  logic byte0;
  logic hit_mode;
  logic hit_restart;
  logic hit_status;
  logic take;
  logic mode_wr;
  logic restart_wr;
  logic restart_ok;
  logic restart_bad;
  logic second_wr;
  logic [1:0] eff_sel;
  logic stopped;
  logic paused;
  logic tick;
  logic count_en;
  logic clear;
  logic overflow;
  logic fault;
  logic [7:0] next_rdata;
  logic [plw_pkg::CNT_W-1:0] limit;

  // =========================================================
  // bus request decode
  assign req = wb_cyc_i & wb_stb_i;
  assign byte0 = wb_sel_i[0];
  assign hit_mode = reg_hit(wb_adr_i, plw_pkg::MODE_IDX);
  assign hit_restart = reg_hit(wb_adr_i, plw_pkg::RESTART_IDX);
  assign hit_status = reg_hit(wb_adr_i, plw_pkg::STATUS_IDX);
  assign wb_ack_o = (state == plw_pkg::BUS_ACK);
  // writes act at the edge where the master samples ack
  assign take = wb_ack_o & req & wb_we_i & byte0;
  assign mode_wr = take & hit_mode;
  assign restart_wr = take & hit_restart;

  // =========================================================
  // bus handshake: mode writes get one wait cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= plw_pkg::BUS_IDLE;
    end else begin
      case (state)
        plw_pkg::BUS_IDLE: begin
          if (req && wb_we_i && hit_mode) begin
            state <= plw_pkg::BUS_WAIT;
          end else if (req) begin
            state <= plw_pkg::BUS_ACK;
          end
        end
        plw_pkg::BUS_WAIT: begin
          state <= plw_pkg::BUS_ACK;
        end
        default: begin
          state <= plw_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // =========================================================
  // read data
  always_comb begin
    if (hit_mode) begin
      next_rdata = mode;
    end else if (hit_restart) begin
      next_rdata = plw_pkg::RESTART_READ;
    end else if (hit_status) begin
      next_rdata = 8'h00;
      next_rdata[plw_pkg::ST_WRITTEN] = mode_written;
      next_rdata[plw_pkg::ST_STOPPED] = stopped;
      next_rdata[plw_pkg::ST_UNSTOP] = option_unstoppable_i;
      next_rdata[plw_pkg::ST_CAUSE] = wd_reset_cause_flag_o;
    end else begin
      next_rdata = 8'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (state != plw_pkg::BUS_ACK && req) begin
      wb_dat_o <= {24'h00_0000, next_rdata};
    end
  end

  // =========================================================
  // mode register, written once after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode <= plw_pkg::MODE_RESET;
      mode_written <= 1'b0;
    end else if (mode_wr && !mode_written) begin
      mode_written <= 1'b1;
      mode.fixed <= plw_pkg::FIXED_BITS;
      mode.interval <= wb_dat_i[2:0];
      if (!option_unstoppable_i) begin
        mode.clk_sel <= wb_dat_i[4:3];
      end else begin
        mode.clk_sel <= plw_pkg::SEL_LOWSPEED;
      end
    end
  end

  // =========================================================
  // count source selection
  assign eff_sel = option_unstoppable_i ? plw_pkg::SEL_LOWSPEED : mode.clk_sel;
  assign stopped = eff_sel[plw_pkg::SEL_STOP_BIT];
  // stoppable option holds the count in halt or stop
  assign paused = !option_unstoppable_i & (halt_i | stop_i);
  assign tick = (eff_sel == plw_pkg::SEL_CRYSTAL) ? crystal_tick_i : lowspeed_osc_clk_i;
  assign count_en = tick & !stopped & !paused;
  assign limit = last_count(eff_sel == plw_pkg::SEL_CRYSTAL, mode.interval);

  // =========================================================
  // restart key and misuse checks
  assign restart_ok = restart_wr & !bit_access_i & (wb_dat_i[7:0] == plw_pkg::RESTART_KEY);
  assign restart_bad = restart_wr & !restart_ok;
  assign second_wr = mode_wr & mode_written;
  assign clear = mode_wr | restart_ok;
  assign overflow = count_en & (cnt == limit) & !clear;
  // a stopped watchdog forgives misuse
  assign fault = overflow | (!stopped & (restart_bad | second_wr));

  // =========================================================
  // counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= '0;
    end else if (clear || fault) begin
      cnt <= '0;
    end else if (count_en) begin
      cnt <= cnt + plw_pkg::CNT_W'(1);
    end
  end

  // =========================================================
  // internal reset pulse and cause flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wd_reset_o <= 1'b0;
    end else begin
      wd_reset_o <= fault;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wd_reset_cause_flag_o <= 1'b0;
    end else if (fault) begin
      wd_reset_cause_flag_o <= 1'b1;
    end
  end

  // =========================================================
  // assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_mode_req;
    state == plw_pkg::BUS_IDLE && req && wb_we_i && hit_mode;
  endsequence

  sequence s_wait_then_ack;
    !wb_ack_o ##1 wb_ack_o;
  endsequence

  property p_mode_wait;
    s_mode_req |=> s_wait_then_ack;
  endproperty
  a_mode_wait: assert property (p_mode_wait)
    else $error("mode write not acked after one wait cycle");

  property p_fast_ack;
    state == plw_pkg::BUS_IDLE && req && !(wb_we_i && hit_mode) |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_fast_ack: assert property (p_fast_ack)
    else $error("single cycle ack missing");

  property p_restart_clear;
    restart_ok |=> cnt == '0 && !wd_reset_o;
  endproperty
  a_restart_clear: assert property (p_restart_clear)
    else $error("good key did not clear counter");

  property p_bad_key;
    restart_bad && !stopped |=> wd_reset_o ##1 wd_reset_cause_flag_o;
  endproperty
  a_bad_key: assert property (p_bad_key)
    else $error("bad restart did not reset");

  property p_key_read;
    wb_ack_o && !wb_we_i && hit_restart |-> wb_dat_o[7:0] == plw_pkg::RESTART_READ;
  endproperty
  a_key_read: assert property (p_key_read)
    else $error("restart register did not read 9AH");

  property p_second_write;
    second_wr && !stopped |=> wd_reset_o && $stable(mode);
  endproperty
  a_second_write: assert property (p_second_write)
    else $error("second mode write not punished");

  property p_mode_clear;
    mode_wr |=> cnt == '0;
  endproperty
  a_mode_clear: assert property (p_mode_clear)
    else $error("mode write did not clear counter");

  property p_overflow;
    count_en && cnt == limit && !clear |=> wd_reset_o && cnt == '0;
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("overflow did not reset");

  property p_fixed_source;
    option_unstoppable_i && mode_wr |=> mode.clk_sel == plw_pkg::SEL_LOWSPEED;
  endproperty
  a_fixed_source: assert property (p_fixed_source)
    else $error("clock select changed in unstoppable option");

  property p_stopped_quiet;
    stopped && (restart_bad || second_wr) && !overflow |=> !wd_reset_o;
  endproperty
  a_stopped_quiet: assert property (p_stopped_quiet)
    else $error("stopped watchdog raised reset");

  property p_pause_hold;
    paused && !clear && !fault |=> $stable(cnt);
  endproperty
  a_pause_hold: assert property (p_pause_hold)
    else $error("counter moved while paused");

  property p_stopped_hold;
    stopped && !clear |=> $stable(cnt);
  endproperty
  a_stopped_hold: assert property (p_stopped_hold)
    else $error("counter moved while stopped");

  property p_unstop_runs;
    option_unstoppable_i && lowspeed_osc_clk_i && !clear && !fault |=>
      cnt == $past(cnt) + plw_pkg::CNT_W'(1);
  endproperty
  a_unstop_runs: assert property (p_unstop_runs)
    else $error("unstoppable watchdog missed a tick");

  property p_flag_set;
    fault |=> wd_reset_o && wd_reset_cause_flag_o;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("watchdog reset did not set cause flag");

  property p_mode_locked;
    mode_written |=> $stable(mode);
  endproperty
  a_mode_locked: assert property (p_mode_locked)
    else $error("mode register changed after first write");

  property p_reset_value;
    $fell(rst_i) |-> mode == plw_pkg::MODE_RESET && cnt == '0;
  endproperty
  a_reset_value: assert property (p_reset_value)
    else $error("bad state after reset");

endmodule

/* File: plw_testbench.sv */
// self-checking testbench of the program loop watchdog
`timescale 1ns/10ps
module testbench;
  localparam logic [31:0] A_MODE = {14'h0000, plw_pkg::MODE_IDX, 2'h0};
  localparam logic [31:0] A_KEY = {14'h0000, plw_pkg::RESTART_IDX, 2'h0};
  localparam logic [31:0] A_STAT = {14'h0000, plw_pkg::STATUS_IDX, 2'h0};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [31:0] adr = 32'h0000_0000;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rd;
  logic [3:0] sel = 4'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic bit_acc = 1'b0;
  logic unstop = 1'b0;
  logic halt = 1'b0;
  logic stop = 1'b0;
  logic ls_tick = 1'b0;
  logic xt_tick = 1'b0;
  logic ack;
  logic wd_rst;
  logic flag;
  logic [31:0] rdat;
  int err_count = 0;
  int n_compared = 0;
  int n;
  int cyc_n;

  always #12.5 clk_i = ~clk_i;

  plw_watchdog DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(rdat),
    .wb_ack_o(ack), .bit_access_i(bit_acc), .option_unstoppable_i(unstop),
    .halt_i(halt), .stop_i(stop), .lowspeed_osc_clk_i(ls_tick),
    .crystal_tick_i(xt_tick), .wd_reset_o(wd_rst), .wd_reset_cause_flag_o(flag));

  // =========================================================
  // shared tasks
  task automatic summarize();
    if (err_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  // one classic cycle; cyc_n counts edges up to the one sampling ack
  task automatic wb(input logic w, input logic [31:0] a, input logic [7:0] d, input logic b);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h00_0000, d};
    sel <= 4'hf;
    bit_acc <= b;
    cyc_n = 0;
    do begin
      @(posedge clk_i);
      cyc_n++;
    end while (ack !== 1'b1 && cyc_n < 20);
    if (ack !== 1'b1) begin
      err_count++;
      summarize();
    end
    rd = rdat;
    cyc <= 1'b0;
    we <= 1'b0;
    bit_acc <= 1'b0;
  endtask

  task automatic pulse(input logic exp);
    logic seen;
    seen = 1'b0;
    #1;
    for (int i = 0; i < 4; i++) begin
      if (wd_rst === 1'b1) seen = 1'b1;
      @(posedge clk_i);
      #1;
    end
    chk("wd_reset", {31'h0, exp}, {31'h0, seen});
  endtask

  // ticks every cycle; n ends as the tick count that caused overflow, or lim
  task automatic run(input logic l, input logic x, input int lim);
    n = 0;
    @(posedge clk_i);
    ls_tick <= l;
    xt_tick <= x;
    do begin
      @(posedge clk_i);
      n++;
    end while (wd_rst !== 1'b1 && n < lim);
    ls_tick <= 1'b0;
    xt_tick <= 1'b0;
    if (wd_rst === 1'b1) n--;
  endtask

  // =========================================================
  // scenarios
  task automatic t_regs();
    chk("flag", 32'h0, {31'h0, flag});
    wb(1'b0, A_MODE, 8'h00, 1'b0);
    chk("mode", 32'h0000_0067, rd);
    chk("rd_wait", 32'h2, cyc_n);
    wb(1'b1, A_KEY, 8'hac, 1'b0);
    wb(1'b0, A_KEY, 8'h00, 1'b0);
    chk("key", 32'h0000_009a, rd);
    wb(1'b0, 32'h0000_0100, 8'h00, 1'b0);
    chk("unmapped", 32'h0, rd);
  endtask

  task automatic t_overflow();
    for (int c = 0; c < 4; c++) begin
      do_reset();
      wb(1'b1, A_MODE, 8'h60 | c[7:0], 1'b0);
      chk("wr_wait", 32'h3, cyc_n);
      wb(1'b0, A_MODE, 8'h00, 1'b0);
      chk("mode", 32'h60 | c, rd);
      run(1'b1, 1'b0, 20000);
      chk("ticks", 32'd2048 << c, n);
      chk("flag", 32'h1, {31'h0, flag});
    end
  endtask

  task automatic t_key();
    do_reset();
    wb(1'b1, A_MODE, 8'h60, 1'b0);
    run(1'b1, 1'b0, 2000);
    wb(1'b1, A_KEY, 8'hac, 1'b0);
    pulse(1'b0);
    run(1'b1, 1'b0, 3000);
    chk("ticks", 32'd2048, n);
    do_reset();
    wb(1'b1, A_KEY, 8'h55, 1'b0);
    pulse(1'b1);
    do_reset();
    wb(1'b1, A_KEY, 8'hac, 1'b1);
    pulse(1'b1);
    do_reset();
    wb(1'b1, A_MODE, 8'h60, 1'b0);
    pulse(1'b0);
    wb(1'b1, A_MODE, 8'h61, 1'b0);
    pulse(1'b1);
  endtask

  task automatic t_clocks();
    do_reset();
    wb(1'b1, A_MODE, 8'h68, 1'b0);
    run(1'b1, 1'b1, 10000);
    chk("xt_ticks", 32'd8192, n);
    do_reset();
    wb(1'b1, A_MODE, 8'h70, 1'b0);
    run(1'b1, 1'b1, 3000);
    chk("stopped", 32'd3000, n);
    wb(1'b1, A_KEY, 8'h55, 1'b0);
    pulse(1'b0);
    wb(1'b1, A_KEY, 8'hac, 1'b1);
    pulse(1'b0);
    wb(1'b1, A_MODE, 8'h60, 1'b0);
    pulse(1'b0);
    wb(1'b0, A_STAT, 8'h00, 1'b0);
    chk("status", 32'h0000_0003, rd);
  endtask

  task automatic t_pause();
    do_reset();
    wb(1'b1, A_MODE, 8'h60, 1'b0);
    run(1'b1, 1'b0, 1000);
    halt <= 1'b1;
    run(1'b1, 1'b0, 500);
    halt <= 1'b0;
    stop <= 1'b1;
    run(1'b1, 1'b0, 500);
    stop <= 1'b0;
    run(1'b1, 1'b0, 3000);
    chk("resume", 32'd1048, n);
  endtask

  task automatic t_unstop();
    unstop <= 1'b1;
    do_reset();
    wb(1'b1, A_MODE, 8'h90, 1'b0);
    wb(1'b0, A_MODE, 8'h00, 1'b0);
    chk("mode", 32'h0000_0060, rd);
    stop <= 1'b1;
    run(1'b1, 1'b1, 2000);
    wb(1'b1, A_KEY, 8'hac, 1'b0);
    pulse(1'b0);
    run(1'b1, 1'b1, 5000);
    chk("ticks", 32'd2048, n);
    stop <= 1'b0;
    unstop <= 1'b0;
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_overflow();
    t_key();
    t_clocks();
    t_pause();
    t_unstop();
    summarize();
  end
endmodule
